// file: include/msfr_pkg.sv
// constants, field layouts and carrier types of the motor status and fault register bank
package msfr_pkg;

    // ---------------------------------------------------------------
    // bus geometry
    // ---------------------------------------------------------------
    localparam int unsigned MSFR_ADDR_W = 8;
    localparam int unsigned MSFR_IDX_W = 6;
    localparam int unsigned MSFR_DATA_W = 32;
    localparam int unsigned MSFR_BE_W = 4;
    localparam int unsigned MSFR_REG_W = 16;

    // ---------------------------------------------------------------
    // register indices, byte address is four times the index
    // ---------------------------------------------------------------
    localparam logic [5:0] MSFR_IDX_FAULT = 6'h00;
    localparam logic [5:0] MSFR_IDX_ROTOR_RATE = 6'h01;
    localparam logic [5:0] MSFR_IDX_ROT_INTERVAL = 6'h02;
    localparam logic [5:0] MSFR_IDX_VCONST = 6'h03;
    localparam logic [5:0] MSFR_IDX_AMPS = 6'h04;
    localparam logic [5:0] MSFR_IDX_IRQ_STAT = 6'h05;
    localparam logic [5:0] MSFR_IDX_IRQ_MASK = 6'h06;

    // ---------------------------------------------------------------
    // reset values and field layouts
    // ---------------------------------------------------------------
    localparam logic [15:0] MSFR_FAULT_RST = 16'h0000;
    localparam logic [15:0] MSFR_MEAS_RST = 16'h0000;
    localparam logic [15:0] MSFR_IRQ_STAT_RST = 16'h0000;
    localparam logic [15:0] MSFR_IRQ_MASK_RST = 16'h0000;
    localparam logic [31:0] MSFR_RDATA_RST = 32'h0000_0000;
    localparam int unsigned MSFR_FAULT_RSVD_BIT = 6;
    localparam logic [15:0] MSFR_FAULT_IMPL = 16'hFFBF;
    localparam int unsigned MSFR_AMPS_W = 11;
    localparam logic [15:0] MSFR_AMPS_MASK = 16'h07FF;

    // bit 15 first, down to bit 0
    typedef struct packed {
        logic thermal_shutdown_flag;
        logic thermal_alert_flag;
        logic supply_overvoltage_flag;
        logic buck_overcurrent_flag;
        logic drive_overcurrent_flag;
        logic pump_undervoltage_flag;
        logic buck_undervoltage_flag;
        logic supply_undervoltage_flag;
        logic ldo_undervoltage_flag;
        logic rsvd6;
        logic closed_loop_stall_flag;
        logic open_loop_stall_flag;
        logic absent_motor_flag;
        logic bemf_const_abnormal_flag;
        logic speed_abnormal_flag;
        logic hw_current_limit_flag;
    } msfr_fault_t;

    typedef struct packed {
        logic [15:0] rotor_rate;
        logic [15:0] rotation_interval;
        logic [15:0] velocity_constant_est;
        logic [10:0] phase_amps_reading;
    } msfr_meas_t;

endpackage

// file: design/msfr_sticky_bank.sv
// bank of sticky flags, set has priority over clear
module msfr_sticky_bank #(
    parameter int unsigned WIDTH = 16,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    output logic [WIDTH-1:0] flags_o
);

    // ---------------------------------------------------------------
    // one flop per flag
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            always_ff @(posedge clk_sys_i)
            begin
                if (!rst_b_i)
                begin
                    flags_o[gi] <= RST_VAL[gi];
                end
                // an event in the clearing cycle is kept
                else if (set_i[gi])
                begin
                    flags_o[gi] <= 1'b1;
                end
                else if (clr_i[gi])
                begin
                    flags_o[gi] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

// file: design/msfr_avmm_port.sv
// avalon-mm handshake: one wait state, then a one-cycle completion
module msfr_avmm_port (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic read_i,
    input wire logic write_i,
    output logic waitrequest_o,
    output logic launch_o,
    output logic rd_done_o,
    output logic wr_done_o
);

    // ---------------------------------------------------------------
    // handshake
    // ---------------------------------------------------------------
    logic req;

    assign req = read_i | write_i;
    // launch loads read data so it stands at the completion edge
    assign launch_o = req & waitrequest_o;
    assign rd_done_o = read_i & ~waitrequest_o;
    assign wr_done_o = write_i & ~waitrequest_o;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            waitrequest_o <= 1'b1;
        end
        else if (launch_o)
        begin
            waitrequest_o <= 1'b0;
        end
        else
        begin
            waitrequest_o <= 1'b1;
        end
    end

endmodule

// file: design/msfr_regs.sv
// status, fault and measurement registers of the motor driver on an avalon-mm slave
//
// Function
// [RQ1] bit 15 latches die over-temperature shutdown until software clears it
// [RQ2] bit 14 latches die temperature warning until cleared
// [RQ3] bit 13 latches supply overvoltage
// [RQ4] bit 12 latches switching regulator overcurrent
// [RQ5] bit 11 latches any motor-drive overcurrent event
// [RQ6] bit 10 latches charge pump undervoltage
// [RQ7] bit 9 latches switching regulator undervoltage
// [RQ8] bit 8 latches supply input undervoltage
// [RQ9] bit 7 latches 3.3 V linear regulator undervoltage
// [RQ10] bit 6 is reserved, never used by software, always zero
// [RQ11] bits 5 to 0 latch the six lock-detect conditions
// [RQ12] fault register resets to zero, each flag cleared by writing one
// [RQ13] rotor rate: read-only 16-bit, tenths of a hertz
// [RQ14] rotation period: read-only 16-bit, units of 10 us
// [RQ15] velocity constant: read-only 16-bit, V/Hz is value over 2 over 1090
// [RQ16] motor current: read-only 11-bit code in bits 10 to 0
// [RQ17] current register bits 15 to 11 read zero, software leaves them alone
// [RQ18] software clears latched faults by writing all ones
// [RQ19] measurement reads have no side effect, writes to them ignored
module msfr_regs (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [7:0] avs_address_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire msfr_pkg::msfr_fault_t fault_cond_i,
    input wire msfr_pkg::msfr_meas_t meas_i,
    input wire logic meas_update_i,
    output msfr_pkg::msfr_fault_t fault_flags_o,
    output logic fault_any_o,
    output logic irq_o
);

    // ---------------------------------------------------------------
    // bus handshake and decode
    // ---------------------------------------------------------------
    logic launch;
    logic rd_done;
    logic wr_done;
    logic [5:0] idx;
    logic [15:0] wmask;

    msfr_avmm_port u_port (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .read_i(avs_read_i),
        .write_i(avs_write_i),
        .waitrequest_o(avs_waitrequest_o),
        .launch_o(launch),
        .rd_done_o(rd_done),
        .wr_done_o(wr_done)
    );

    // low address bits are ignored: every register is one aligned word
    assign idx = avs_address_i[7:2];

    // only the low two byte lanes carry register bits
    assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}} & avs_writedata_i[15:0];

    // ---------------------------------------------------------------
    // fault flags
    // ---------------------------------------------------------------
    logic [15:0] fault_set;
    logic [15:0] fault_clr;
    logic [15:0] fault_q;

    // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] latch the upper faults
    // [RQ6] [RQ7] [RQ8] [RQ9] [RQ11] latch undervoltage and lock faults
    // [RQ10] reserved bit never sets
    assign fault_set = fault_cond_i & msfr_pkg::MSFR_FAULT_IMPL;

    // [RQ12] write one clears, [RQ18] all ones clears every flag in the enabled byte lanes unless its condition is present
    assign fault_clr = (wr_done && idx == msfr_pkg::MSFR_IDX_FAULT) ? (wmask & msfr_pkg::MSFR_FAULT_IMPL) : 16'h0000;

    // [RQ12] sticky flags reset to zero
    msfr_sticky_bank #(
        .WIDTH(16),
        .RST_VAL(msfr_pkg::MSFR_FAULT_RST)
    ) u_fault (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .set_i(fault_set),
        .clr_i(fault_clr),
        .flags_o(fault_q)
    );

    assign fault_flags_o = fault_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            fault_any_o <= 1'b0;
        end
        else
        begin
            fault_any_o <= |((fault_q & ~fault_clr) | fault_set);
        end
    end

    // ---------------------------------------------------------------
    // measurement registers
    // ---------------------------------------------------------------
    logic [15:0] rotor_rate_q;
    logic [15:0] rotation_interval_q;
    logic [15:0] velocity_constant_est_q;
    logic [15:0] phase_amps_reading_q;

    // values only move on the estimator strobe, so a bus read never sees a half update
    // [RQ13] [RQ14] [RQ15] capture the 16-bit readings
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            rotor_rate_q <= msfr_pkg::MSFR_MEAS_RST;
            rotation_interval_q <= msfr_pkg::MSFR_MEAS_RST;
            velocity_constant_est_q <= msfr_pkg::MSFR_MEAS_RST;
        end
        else if (meas_update_i)
        begin
            rotor_rate_q <= meas_i.rotor_rate;
            rotation_interval_q <= meas_i.rotation_interval;
            velocity_constant_est_q <= meas_i.velocity_constant_est;
        end
    end

    // [RQ16] [RQ17] 11-bit current code, upper bits zero
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            phase_amps_reading_q <= msfr_pkg::MSFR_MEAS_RST;
        end
        else if (meas_update_i)
        begin
            phase_amps_reading_q <= {5'h00, meas_i.phase_amps_reading} & msfr_pkg::MSFR_AMPS_MASK;
        end
    end

    // ---------------------------------------------------------------
    // interrupt status and mask
    // ---------------------------------------------------------------
    logic [15:0] irq_set;
    logic [15:0] irq_clr;
    logic [15:0] irq_stat_q;
    logic [15:0] irq_mask_q;

    // event is a flag going from clear to set, same layout as the fault register
    assign irq_set = fault_set & ~fault_q;
    // a read clears only the bits it returned, so an event landing after the data was taken is not lost
    assign irq_clr = (rd_done && idx == msfr_pkg::MSFR_IDX_IRQ_STAT) ? avs_readdata_o[15:0] : 16'h0000;

    msfr_sticky_bank #(
        .WIDTH(16),
        .RST_VAL(msfr_pkg::MSFR_IRQ_STAT_RST)
    ) u_irq (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .set_i(irq_set),
        .clr_i(irq_clr),
        .flags_o(irq_stat_q)
    );

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            irq_mask_q <= msfr_pkg::MSFR_IRQ_MASK_RST;
        end
        else if (wr_done && idx == msfr_pkg::MSFR_IDX_IRQ_MASK)
        begin
            irq_mask_q <= (irq_mask_q & ~{{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}}) | wmask;
        end
    end

    // one cycle behind status, traded for a registered output
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(irq_stat_q & irq_mask_q & msfr_pkg::MSFR_FAULT_IMPL);
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    logic [15:0] rd_mux;

    // [RQ19] reads of measurements only select, nothing else changes
    always_comb
    begin
        rd_mux = 16'h0000;
        unique case (idx)
            msfr_pkg::MSFR_IDX_FAULT: rd_mux = fault_q & msfr_pkg::MSFR_FAULT_IMPL;
            msfr_pkg::MSFR_IDX_ROTOR_RATE: rd_mux = rotor_rate_q;
            msfr_pkg::MSFR_IDX_ROT_INTERVAL: rd_mux = rotation_interval_q;
            msfr_pkg::MSFR_IDX_VCONST: rd_mux = velocity_constant_est_q;
            msfr_pkg::MSFR_IDX_AMPS: rd_mux = phase_amps_reading_q;
            msfr_pkg::MSFR_IDX_IRQ_STAT: rd_mux = irq_stat_q & msfr_pkg::MSFR_FAULT_IMPL;
            msfr_pkg::MSFR_IDX_IRQ_MASK: rd_mux = irq_mask_q;
            default: rd_mux = 16'h0000;
        endcase
    end

    // data is loaded in the wait cycle and held through the completion edge
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_b_i)
        begin
            avs_readdata_o <= msfr_pkg::MSFR_RDATA_RST;
        end
        else if (launch && avs_read_i)
        begin
            avs_readdata_o <= {16'h0000, rd_mux};
        end
    end

endmodule

// file: bench/msfr_regs_sva.sv
// assertion checker for the motor status and fault register bank
module msfr_regs_sva (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [7:0] avs_address_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire msfr_pkg::msfr_fault_t fault_cond_i,
    input wire msfr_pkg::msfr_meas_t meas_i,
    input wire logic meas_update_i,
    input wire msfr_pkg::msfr_fault_t fault_flags_o,
    input wire logic fault_any_o,
    input wire logic irq_o
);
    // ----
    // handshake and flag relations
    // ----
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);
    logic rd_done;
    logic wr0;
    assign rd_done = avs_read_i && !avs_waitrequest_o;
    assign wr0 = avs_write_i && !avs_waitrequest_o && avs_address_i[7:2] == msfr_pkg::MSFR_IDX_FAULT;
    wait_one_a:
        assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("waitrequest not low for one cycle");
    idle_wait_a:
        assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
        else $error("waitrequest low while idle");
    flag_set_a:
        assert property (fault_cond_i != 16'h0000 |=>
            (fault_flags_o & $past(fault_cond_i) & 16'hFFBF) == ($past(fault_cond_i) & 16'hFFBF))
        else $error("fault flag not latched");
    rsvd_zero_a:
        assert property (fault_flags_o.rsvd6 == 1'b0)
        else $error("reserved fault bit set");
    sticky_hold_a:
        assert property (!wr0 |=> (fault_flags_o & $past(fault_flags_o)) == $past(fault_flags_o))
        else $error("fault flag dropped without clear");
    w1c_clear_a:
        assert property (wr0 && avs_byteenable_i[1:0] == 2'b11 |=>
            (fault_flags_o & $past(avs_writedata_i[15:0]) & ~$past(fault_cond_i)) == 16'h0000)
        else $error("write one did not clear flag");
    amps_top_a:
        assert property (rd_done && avs_address_i[7:2] == msfr_pkg::MSFR_IDX_AMPS |-> avs_readdata_o[15:11] == 5'h00)
        else $error("current upper bits not zero");
    any_flag_a:
        assert property (fault_any_o == (fault_flags_o != 16'h0000))
        else $error("summary flag disagrees");
    clear_c: cover property (wr0);
    irq_c: cover property ($rose(irq_o));
    amps_c: cover property (rd_done && avs_address_i[7:2] == msfr_pkg::MSFR_IDX_AMPS);
endmodule

bind msfr_regs msfr_regs_sva i_msfr_regs_sva (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_byteenable_i(avs_byteenable_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .fault_cond_i(fault_cond_i), .meas_i(meas_i),
    .meas_update_i(meas_update_i), .fault_flags_o(fault_flags_o), .fault_any_o(fault_any_o), .irq_o(irq_o));

// file: bench/tb_msfr_regs.sv
// self-checking bench of the motor status and fault register bank
module tb_msfr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [15:0] cond;
        logic [15:0] exp;
    } msfr_row_t;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    msfr_pkg::msfr_fault_t fault_cond_i = 16'h0000;
    msfr_pkg::msfr_meas_t meas_i = '0;
    logic meas_update_i = 1'b0;
    msfr_pkg::msfr_fault_t fault_flags_o;
    logic fault_any_o;
    logic irq_o;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] rd;
    // bit 6 is refused in every row that tries it
    msfr_row_t rows [5] = '{'{16'h8000, 16'h8000}, '{16'h4040, 16'h4000}, '{16'h3F3F, 16'h3F3F},
        '{16'h00C0, 16'h0080}, '{16'hFFFF, 16'hFFBF}};
    logic [15:0] mexp [4] = '{16'hA5C3, 16'h0FF0, 16'h8001, 16'h07FF};

    msfr_regs i_msfr_regs (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .fault_cond_i(fault_cond_i), .meas_i(meas_i), .meas_update_i(meas_update_i),
        .fault_flags_o(fault_flags_o), .fault_any_o(fault_any_o), .irq_o(irq_o));

    always #10 clk_sys_i = ~clk_sys_i;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one edge passes first so a release is never re-driven in the same step
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
        @(posedge clk_sys_i);
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= {16'h0000, wd};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do
            @(posedge clk_sys_i);
        while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [5:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 16'h0000);
        chk(what, rd, exp);
    endtask

    task automatic pulse(input logic [15:0] c);
        @(posedge clk_sys_i);
        fault_cond_i <= c;
        @(posedge clk_sys_i);
        fault_cond_i <= 16'h0000;
    endtask

    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 7; i++)
            rchk("reset value", i[5:0], 32'h0);
        foreach (rows[i])
        begin
            pulse(rows[i].cond);
            rchk("fault flags", 6'h00, {16'h0000, rows[i].exp});
            chk("flag port", fault_flags_o, {16'h0000, rows[i].exp});
            bus(1'b1, 6'h00, 16'hFFFF);
            rchk("cleared flags", 6'h00, 32'h0);
        end
        // masked events still latch in status, read clears it
        rchk("irq status", 6'h05, 32'h0000FFBF);
        rchk("irq status clear", 6'h05, 32'h0);
        bus(1'b1, 6'h06, 16'h8000);
        pulse(16'h4000);
        repeat (3) @(posedge clk_sys_i);
        chk("irq masked", irq_o, 32'h0);
        pulse(16'h8000);
        repeat (3) @(posedge clk_sys_i);
        chk("irq raised", irq_o, 32'h1);
        rchk("irq status", 6'h05, 32'h0000C000);
        repeat (2) @(posedge clk_sys_i);
        chk("irq dropped", irq_o, 32'h0);
        // a condition still present at the clear edge wins
        fault_cond_i <= 16'h0800;
        bus(1'b1, 6'h00, 16'hFFFF);
        rchk("held flag", 6'h00, 32'h0000_0800);
        fault_cond_i <= 16'h0000;
        pulse(16'h0001);
        avs_byteenable_i <= 4'h1;
        bus(1'b1, 6'h00, 16'hFFFF);
        avs_byteenable_i <= 4'hF;
        rchk("low byte clear", 6'h00, 32'h0000_0800);
        bus(1'b1, 6'h00, 16'hFFFF);
        @(posedge clk_sys_i);
        meas_i <= {16'hA5C3, 16'h0FF0, 16'h8001, 11'h7FF};
        meas_update_i <= 1'b1;
        @(posedge clk_sys_i);
        meas_i <= '0;
        meas_update_i <= 1'b0;
        for (int i = 1; i < 5; i++)
            rchk("measurement", i[5:0], {16'h0000, mexp[i-1]});
        for (int i = 1; i < 5; i++)
        begin
            bus(1'b1, i[5:0], 16'h5A5A);
            rchk("read-only kept", i[5:0], {16'h0000, mexp[i-1]});
        end
        bus(1'b1, 6'h09, 16'hFFFF);
        rchk("unmapped", 6'h09, 32'h0);
        // reset in mid-run drops latched flags
        pulse(16'h2000);
        // the summary flop updates on the edge that pulse returns on
        @(posedge clk_sys_i);
        chk("summary set", fault_any_o, 32'h1);
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        rchk("flags after reset", 6'h00, 32'h0);
        chk("summary after reset", fault_any_o, 32'h0);
        end_of_test();
    end
endmodule
